// File: src/eewg_pkg.sv
// shared constants for the write guard and bulk operation logic
package eewg_pkg;

   // system clock rate
   localparam int CLK_HZ = 20_000_000;

   // self-timed program/erase pulse, in milliseconds
   localparam int PROG_PULSE_MS = 5;
   // longest time, so the integer division rounds down
   localparam int PROG_PULSE_CYC = PROG_PULSE_MS * (CLK_HZ / 1000);

   // default array geometry, word organization
   localparam int ADDR_BITS = 6;
   localparam int DATA_BITS = 16;

   // opcode field, two bits after the start bit
   localparam int OPC_BITS = 2;
   localparam logic [1:0] OPC_SPECIAL = 2'h0;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_ERASE = 2'h3;

   // sub-code held in the two top address bits of a special opcode
   localparam logic [1:0] AUX_LOCK = 2'h0;
   localparam logic [1:0] AUX_FILL = 2'h1;
   localparam logic [1:0] AUX_CLEAR = 2'h2;
   localparam logic [1:0] AUX_UNLOCK = 2'h3;

   // reset values
   localparam logic UNLOCK_RST = 1'b0;
   localparam logic BUSY_RST = 1'b0;

   // serial decode phases
   typedef enum logic [2:0] {
      EEWG_IDLE,
      EEWG_OPCODE,
      EEWG_ADDRESS,
      EEWG_DATA,
      EEWG_READOUT,
      EEWG_DONE
   } eewg_phase_t;

   // bulk operation armed for the next chip select fall
   typedef enum logic [1:0] {
      EEWG_BULK_NONE,
      EEWG_BULK_CLEAR,
      EEWG_BULK_FILL
   } eewg_bulk_t;

endpackage

// File: src/eewg_sync.sv
`timescale 1ns/100ps
// two-stage synchronizer for asynchronous pins
module eewg_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;

endmodule

// File: src/eewg_array.sv
`timescale 1ns/100ps
// flip-flop storage array with one read port and a whole-array fill
module eewg_array
   import eewg_pkg::*;
#(
   parameter int ADDR_W = ADDR_BITS,
   parameter int DATA_W = DATA_BITS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data,
   input wire logic fill_en,
   input wire logic [DATA_W-1:0] fill_value
);

   localparam int WORDS = 1 << ADDR_W;

   logic [DATA_W-1:0] mem_reg [WORDS];
   logic [DATA_W-1:0] mem_next [WORDS];

   // every word takes the fill value at once, no prior clear needed
   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         mem_next[i] = fill_en ? fill_value : mem_reg[i]; // see R11
      end
   end

   // power-up leaves the array in the cleared (all ones) state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_reg[i] <= '1;
         end
      end else begin
         for (int i = 0; i < WORDS; i++) begin
            mem_reg[i] <= mem_next[i];
         end
      end
   end

   // read path is independent of the lock state
   assign rd_data = mem_reg[rd_addr]; // see R5

endmodule

// File: src/eewg_guard.sv
// Function
// R1: write-enable latch starts cleared after power-up reset.
// R2: programming or clearing needs a prior accepted unlock instruction.
// R3: latch stays set until reset or a lock instruction arrives.
// R4: while locked, write, fill, erase and clear instructions do nothing.
// R5: reads return stored data regardless of the latch.
// R6: host keeps chip select low a minimum time after bulk instructions.
// R7: chip select fall after accepted clear-all starts a timed whole-array clear.
// R8: timed cycle completes with no further serial clock pulses.
// R9: after clear-all every array bit reads as one.
// R10: chip select fall after accepted fill-all starts timed whole-array write.
// R11: fill-all stores data everywhere without a prior clear.
// R12: while selected during a cycle, data out shows ready/busy.
// R13: ready/busy is low while busy, high when ready.
// R14: serial data in is sampled on serial clock rising edges.
// R15: instruction is start bit, opcode, address, then data for writes.
// R16: bulk and write instructions need the program-allow pin high; lock/unlock ignore it.
// R17: shifter resets while deselected; decode after full opcode and address.
// R18: refused bulk instruction starts no cycle; ready stays high.
`timescale 1ns/100ps
module eewg_guard
   import eewg_pkg::*;
#(
   parameter int ADDR_W = ADDR_BITS,
   parameter int DATA_W = DATA_BITS,
   parameter int PROG_CYCLES = PROG_PULSE_CYC,
   parameter bit HAS_PROGRAM_ALLOW = 1'b1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chip_select,
   input wire logic serial_clock_input,
   input wire logic serial_data_input,
   input wire logic program_allow_pin,
   output logic serial_data_output,
   output logic serial_data_output_en,
   output logic program_unlocked,
   output logic cycle_busy
);

   // shift counter covers the longer of the address and data fields
   localparam int CNT_MAX = (ADDR_W > DATA_W) ? ADDR_W : DATA_W;
   localparam int CNT_W = $clog2(CNT_MAX + 1);
   localparam int BUSY_W = $clog2(PROG_CYCLES + 1);

   // pin synchronization
   // data in and serial clock share the same two-flop lag, so bits stay
   // lined up with the clock edge that samples them
   logic [3:0] pins_sync;
   logic cs_s;
   logic sk_s;
   logic di_s;
   logic pa_s;

   eewg_sync #(
      .WIDTH(4)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({program_allow_pin, serial_data_input, serial_clock_input, chip_select}),
      .sync_out(pins_sync)
   );

   assign cs_s = pins_sync[0];
   assign sk_s = pins_sync[1];
   assign di_s = pins_sync[2];
   assign pa_s = pins_sync[3];

   // state
   eewg_phase_t phase_reg;
   eewg_phase_t phase_next;
   eewg_bulk_t pending_reg;
   eewg_bulk_t pending_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [1:0] opcode_reg;
   logic [1:0] opcode_next;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic [DATA_W-1:0] data_reg;
   logic [DATA_W-1:0] data_next;
   logic [DATA_W-1:0] fill_value_reg;
   logic [DATA_W-1:0] fill_value_next;
   logic unlock_reg;
   logic unlock_next;
   logic busy_reg;
   logic busy_next;
   logic [BUSY_W-1:0] busy_cnt_reg;
   logic [BUSY_W-1:0] busy_cnt_next;
   logic status_show_reg;
   logic status_show_next;
   logic do_reg;
   logic do_next;
   logic do_en_reg;
   logic do_en_next;
   logic sk_prev_reg;
   logic cs_prev_reg;

   logic sk_rise;
   logic cs_fall;
   logic fill_en;
   logic [DATA_W-1:0] rd_data;
   logic [ADDR_W-1:0] full_addr;

   // edges seen on the synchronized pins
   assign sk_rise = sk_s & ~sk_prev_reg; // see R14
   assign cs_fall = cs_prev_reg & ~cs_s;
   // array is written once the timer has run out
   assign fill_en = busy_reg & (busy_cnt_reg == '0);
   // address including the bit arriving on this clock edge
   assign full_addr = {addr_reg[ADDR_W-2:0], di_s};

   // bulk operations need the latch and, if fitted, the allow pin
   function automatic logic bulk_allowed(input logic unlocked, input logic allow);
      bulk_allowed = unlocked & (allow | ~HAS_PROGRAM_ALLOW); // see R2 R4 R16
   endfunction

   // read address includes the bit arriving on this edge, so the word is
   // fetched in time for the dummy bit that precedes it
   eewg_array #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_array (
      .clock(clock),
      .rst_n(rst_n),
      .rd_addr(full_addr),
      .rd_data(rd_data),
      .fill_en(fill_en),
      .fill_value(fill_value_reg)
   );

   // serial instruction decode and timed cycle control
   always_comb begin
      phase_next = phase_reg;
      pending_next = pending_reg;
      count_next = count_reg;
      opcode_next = opcode_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      fill_value_next = fill_value_reg;
      unlock_next = unlock_reg;
      busy_next = busy_reg;
      busy_cnt_next = busy_cnt_reg;
      status_show_next = status_show_reg;
      do_next = do_reg;

      // timer runs on the system clock only, serial clock not needed
      // the array takes its new contents on the last busy clock, so a poll
      // that already sees ready finds them in place
      if (busy_reg) begin
         if (busy_cnt_reg == '0) begin
            busy_next = 1'b0; // see R8
         end else begin
            busy_cnt_next = busy_cnt_reg - 1'b1; // see R8
         end
      end

      if (!cs_s) begin
         // deselect clears the shifter so a broken frame cannot decode
         phase_next = EEWG_IDLE; // see R17
         count_next = '0; // see R17
         pending_next = EEWG_BULK_NONE;
         // an armed bulk operation fires only on the fall that ends its frame
         if (cs_fall && pending_reg != EEWG_BULK_NONE && !busy_reg) begin
            busy_next = 1'b1; // see R7 R10
            busy_cnt_next = BUSY_W'(PROG_CYCLES - 1);
            status_show_next = 1'b1;
            if (pending_reg == EEWG_BULK_FILL) begin
               fill_value_next = data_reg; // see R10
            end else begin
               fill_value_next = '1; // see R9
            end
         end
      end else if (sk_rise) begin
         unique case (phase_reg)
            EEWG_IDLE: begin
               // a start bit while busy is ignored, status stays up
               if (di_s && !busy_reg) begin
                  phase_next = EEWG_OPCODE; // see R15
                  count_next = CNT_W'(OPC_BITS);
                  status_show_next = 1'b0;
               end
            end
            EEWG_OPCODE: begin
               opcode_next = {opcode_reg[0], di_s};
               count_next = count_reg - 1'b1;
               if (count_reg == CNT_W'(1)) begin
                  phase_next = EEWG_ADDRESS;
                  count_next = CNT_W'(ADDR_W);
               end
            end
            EEWG_ADDRESS: begin
               addr_next = full_addr;
               count_next = count_reg - 1'b1;
               if (count_reg == CNT_W'(1)) begin
                  // decode only after the full address is in
                  phase_next = EEWG_DONE; // see R17
                  unique case (opcode_reg)
                     OPC_READ: begin
                        phase_next = EEWG_READOUT; // see R5
                        data_next = rd_data;
                        count_next = CNT_W'(DATA_W);
                        do_next = 1'b0;
                     end
                     OPC_SPECIAL: begin
                        unique case (full_addr[ADDR_W-1 -: 2])
                           AUX_UNLOCK: unlock_next = 1'b1; // see R2 R3
                           AUX_LOCK: unlock_next = 1'b0; // see R3 R4
                           AUX_FILL: begin
                              phase_next = EEWG_DATA; // see R15
                              count_next = CNT_W'(DATA_W);
                           end
                           AUX_CLEAR: begin
                              if (bulk_allowed(unlock_reg, pa_s)) begin
                                 pending_next = EEWG_BULK_CLEAR; // see R7 R18
                              end
                           end
                        endcase
                     end
                     // single-word programming is not built; dropped like a locked one
                     OPC_WRITE, OPC_ERASE: phase_next = EEWG_DONE; // see R4
                  endcase
               end
            end
            EEWG_DATA: begin
               // fill data enters msb first; arming waits for the last bit
               data_next = {data_reg[DATA_W-2:0], di_s};
               count_next = count_reg - 1'b1;
               if (count_reg == CNT_W'(1)) begin
                  phase_next = EEWG_DONE;
                  if (bulk_allowed(unlock_reg, pa_s)) begin
                     pending_next = EEWG_BULK_FILL; // see R10 R18
                  end
               end
            end
            EEWG_READOUT: begin
               // one word per frame, no address roll-over
               if (count_reg == '0) begin
                  phase_next = EEWG_DONE;
               end else begin
                  do_next = data_reg[DATA_W-1];
                  data_next = {data_reg[DATA_W-2:0], 1'b0};
                  count_next = count_reg - 1'b1;
               end
            end
            EEWG_DONE: begin
               // extra clocks after a complete instruction are ignored
               phase_next = EEWG_DONE;
            end
         endcase
      end

      // status pin value follows the timer when not reading out
      if (phase_next != EEWG_READOUT) begin
         do_next = ~busy_next; // see R13
      end
      do_en_next = cs_s & (status_show_next | (phase_next == EEWG_READOUT)); // see R12
   end

   // register update
   // limitation: rst_n stands in for power-up, so the latch does not survive it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= EEWG_IDLE;
         pending_reg <= EEWG_BULK_NONE;
         count_reg <= '0;
         opcode_reg <= '0;
         addr_reg <= '0;
         data_reg <= '0;
         fill_value_reg <= '1;
         unlock_reg <= UNLOCK_RST; // see R1
         busy_reg <= BUSY_RST;
         busy_cnt_reg <= '0;
         status_show_reg <= 1'b0;
         do_reg <= 1'b1;
         do_en_reg <= 1'b0;
         sk_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         pending_reg <= pending_next;
         count_reg <= count_next;
         opcode_reg <= opcode_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         fill_value_reg <= fill_value_next;
         unlock_reg <= unlock_next;
         busy_reg <= busy_next;
         busy_cnt_reg <= busy_cnt_next;
         status_show_reg <= status_show_next;
         do_reg <= do_next;
         do_en_reg <= do_en_next;
         sk_prev_reg <= sk_s;
         cs_prev_reg <= cs_s;
      end
   end

   // outputs straight from flops, so no decode glitch reaches the pins
   assign serial_data_output = do_reg;
   assign serial_data_output_en = do_en_reg;
   assign program_unlocked = unlock_reg;
   assign cycle_busy = busy_reg;

endmodule

// File: verif/eewg_host.sv
`timescale 1ns/100ps
// host side of the serial link: selects, clocks and shifts frames
module eewg_host (
   input wire logic clock,
   input wire logic serial_data_output,
   output logic chip_select,
   output logic serial_clock_input,
   output logic serial_data_input
);
   localparam int HALF = 6; // keeps each clock level above four system clocks

   // idle pins at time zero; serial clock stands still outside frames
   initial begin
      chip_select = 1'b0;
      serial_clock_input = 1'b0;
      serial_data_input = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask

   // one frame, msb first; data moves while the clock is low
   task automatic xfer(input logic [24:0] bits, input int n, output logic [24:0] got);
      got = '0;
      chip_select <= 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_input <= bits[i];
         hold(HALF);
         serial_clock_input <= 1'b1;
         hold(HALF);
         got[i] = serial_data_output;
         serial_clock_input <= 1'b0;
      end
      hold(HALF);
      chip_select <= 1'b0;
      serial_data_input <= ~serial_data_input; // no stale level while deselected
      hold(2 * HALF);
   endtask
endmodule

// File: verif/eewg_guard_properties.sv
`timescale 1ns/100ps
// pin-level checks of the write guard and its timed cycle
module eewg_guard_checker
   import eewg_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_PULSE_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chip_select,
   input wire logic serial_clock_input,
   input wire logic serial_data_input,
   input wire logic program_allow_pin,
   input wire logic serial_data_output,
   input wire logic serial_data_output_en,
   input wire logic program_unlocked,
   input wire logic cycle_busy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [31:0] busy_cnt_reg;
   logic [31:0] busy_cnt_next;

   // length of the running cycle; a counter since the span is too long to unroll
   always_comb begin
      busy_cnt_next = cycle_busy ? busy_cnt_reg + 32'h1 : 32'h0;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) busy_cnt_reg <= 32'h0;
      else busy_cnt_reg <= busy_cnt_next;
   end

   property p_busy_len; $fell(cycle_busy) |-> busy_cnt_reg == PROG_CYCLES; endproperty
   a_busy_len: assert property (p_busy_len) else $error("timed cycle length wrong");
   property p_busy_cap; cycle_busy |-> busy_cnt_reg < PROG_CYCLES; endproperty
   a_busy_cap: assert property (p_busy_cap) else $error("timed cycle overran");
   property p_busy_unlocked; $rose(cycle_busy) |-> program_unlocked && $past(program_unlocked, 8); endproperty
   a_busy_unlocked: assert property (p_busy_unlocked) else $error("cycle started while locked");
   property p_busy_cs_fall; $rose(cycle_busy) |-> !$past(chip_select, 2) && $past(chip_select, 8); endproperty
   a_busy_cs_fall: assert property (p_busy_cs_fall) else $error("cycle not started by deselect");
   property p_busy_allow; $rose(cycle_busy) |-> $past(program_allow_pin, 8); endproperty
   a_busy_allow: assert property (p_busy_allow) else $error("cycle started with allow pin low");
   property p_status_busy;
      cycle_busy && $past(cycle_busy) && serial_data_output_en |-> !serial_data_output;
   endproperty
   a_status_busy: assert property (p_status_busy) else $error("ready shown while busy");
   property p_status_ready;
      $fell(cycle_busy) && chip_select |-> ##[0:2] (serial_data_output_en && serial_data_output);
   endproperty
   a_status_ready: assert property (p_status_ready) else $error("ready not shown after cycle");
   property p_en_release; $fell(chip_select) |-> ##[1:6] !serial_data_output_en; endproperty
   a_en_release: assert property (p_en_release) else $error("data out kept after deselect");
   property p_en_select; $rose(serial_data_output_en) |-> chip_select && $past(chip_select, 2); endproperty
   a_en_select: assert property (p_en_select) else $error("data out driven unselected");
   property p_lock_steady; $changed(program_unlocked) |-> chip_select && !cycle_busy; endproperty
   a_lock_steady: assert property (p_lock_steady) else $error("latch changed outside a frame");

   c_busy: cover property ($rose(cycle_busy));
   c_ready: cover property ($fell(cycle_busy) && chip_select);
   c_unlock: cover property ($rose(program_unlocked));
endmodule

bind eewg_guard eewg_guard_checker #(.PROG_CYCLES(PROG_CYCLES)) u_eewg_guard_checker (
   .clock(clock), .rst_n(rst_n), .chip_select(chip_select), .serial_clock_input(serial_clock_input),
   .serial_data_input(serial_data_input), .program_allow_pin(program_allow_pin),
   .serial_data_output(serial_data_output), .serial_data_output_en(serial_data_output_en),
   .program_unlocked(program_unlocked), .cycle_busy(cycle_busy));

// File: verif/eewg_guard_tb_top.sv
`timescale 1ns/100ps
// bench: host model on the pins, array contents seen through reads
module eewg_guard_tb_top;
   import eewg_pkg::*;
   localparam int PROG_CYC = 20; // short timed cycle keeps the run brief
   logic clock = 1'b0;
   logic rst_n;
   logic program_allow_pin;
   logic chip_select;
   logic serial_clock_input;
   logic serial_data_input;
   logic serial_data_output;
   logic serial_data_output_en;
   logic program_unlocked;
   logic cycle_busy;
   logic line_seen;
   int mismatches = 0;
   int num_checks = 0;
   logic [24:0] got;

   // system clock
   always #25 clock = ~clock;

   eewg_guard #(.PROG_CYCLES(PROG_CYC)) u_eewg_guard (
      .clock(clock), .rst_n(rst_n), .chip_select(chip_select), .serial_clock_input(serial_clock_input),
      .serial_data_input(serial_data_input), .program_allow_pin(program_allow_pin),
      .serial_data_output(serial_data_output), .serial_data_output_en(serial_data_output_en),
      .program_unlocked(program_unlocked), .cycle_busy(cycle_busy));

   // a released data out line shows a changed level, not the last one
   assign line_seen = serial_data_output_en ? serial_data_output : ~serial_data_output;

   eewg_host u_eewg_host (
      .clock(clock), .serial_data_output(line_seen),
      .chip_select(chip_select), .serial_clock_input(serial_clock_input), .serial_data_input(serial_data_input));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic rd(input logic [5:0] addr, input logic [15:0] exp);
      u_eewg_host.xfer({1'b1, OPC_READ, addr, 16'h0000}, 25, got);
      check("dummy bit", {15'h0000, got[16]}, 16'h0000);
      check("read word", got[15:0], exp);
   endtask

   // special frame; bulk ones are polled while selected for busy then ready
   task automatic special(input logic [1:0] sub, input logic [15:0] data, input logic ok);
      logic [24:0] f;
      f = {1'b1, OPC_SPECIAL, sub, 4'h0, data};
      u_eewg_host.xfer(sub == AUX_FILL ? f : f >> 16, sub == AUX_FILL ? 25 : 9, got);
      if (sub == AUX_FILL || sub == AUX_CLEAR) begin
         u_eewg_host.chip_select <= 1'b1;
         u_eewg_host.hold(6);
         check("busy", {15'h0000, cycle_busy}, {15'h0000, ok});
         check("busy shown", {15'h0000, serial_data_output_en & ~serial_data_output}, {15'h0000, ok});
         u_eewg_host.hold(30);
         check("ready", {13'h0000, cycle_busy, serial_data_output_en, serial_data_output}, {14'h0000, ok, 1'b1});
         u_eewg_host.chip_select <= 1'b0;
         u_eewg_host.hold(12);
      end
   endtask

   task automatic t_refused();
      check("unlocked", {15'h0000, program_unlocked}, 16'h0000);
      rd(6'h00, 16'hFFFF);
      u_eewg_host.xfer(25'h0000013, 5, got); // unlock frame cut short
      check("unlocked", {15'h0000, program_unlocked}, 16'h0000);
      special(AUX_FILL, 16'h1234, 1'b0);
      rd(6'h3F, 16'hFFFF);
   endtask

   task automatic t_fill_clear();
      special(AUX_UNLOCK, 16'h0000, 1'b0);
      check("unlocked", {15'h0000, program_unlocked}, 16'h0001);
      special(AUX_FILL, 16'hA5C3, 1'b1);
      rd(6'h00, 16'hA5C3);
      rd(6'h3F, 16'hA5C3);
      special(AUX_FILL, 16'h5A3C, 1'b1);
      rd(6'h2A, 16'h5A3C);
      special(AUX_CLEAR, 16'h0000, 1'b1);
      rd(6'h15, 16'hFFFF);
      check("unlocked", {15'h0000, program_unlocked}, 16'h0001);
   endtask

   task automatic t_allow_lock();
      program_allow_pin <= 1'b0;
      special(AUX_FILL, 16'h0F0F, 1'b0);
      special(AUX_LOCK, 16'h0000, 1'b0);
      check("unlocked", {15'h0000, program_unlocked}, 16'h0000);
      special(AUX_UNLOCK, 16'h0000, 1'b0);
      check("unlocked", {15'h0000, program_unlocked}, 16'h0001);
      program_allow_pin <= 1'b1;
      special(AUX_FILL, 16'h0F0F, 1'b1);
      special(AUX_LOCK, 16'h0000, 1'b0);
      check("unlocked", {15'h0000, program_unlocked}, 16'h0000);
      special(AUX_CLEAR, 16'h0000, 1'b0);
      rd(6'h01, 16'h0F0F);
   endtask

   task automatic t_reset_mid();
      special(AUX_UNLOCK, 16'h0000, 1'b0);
      rst_n <= 1'b0;
      u_eewg_host.hold(2);
      rst_n <= 1'b1;
      u_eewg_host.hold(4);
      check("unlocked", {15'h0000, program_unlocked}, 16'h0000);
      rd(6'h02, 16'hFFFF);
   endtask

   // main sequence
   initial begin
      rst_n <= 1'b0;
      program_allow_pin <= 1'b1;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      u_eewg_host.hold(4);
      t_refused();
      t_fill_clear();
      t_allow_lock();
      t_reset_mid();
      print_verdict();
   end

   // watchdog, more than five times the expected run
   initial begin
      repeat (30000) @(posedge clock);
      mismatches++;
      print_verdict();
   end
endmodule
